/* src/rac_pkg.sv */
// Package with constants and types for the reservation acquire command block.
package rac_pkg;

  // ********************************************************************
  // Command dword 10 field positions.
  // ********************************************************************
  localparam int unsigned ACTION_LSB = 0;
  localparam int unsigned ACTION_W   = 3;
  localparam int unsigned SKIP_BIT   = 3;
  localparam int unsigned KIND_LSB   = 8;
  localparam int unsigned KIND_W     = 8;

  // Action codes and reservation kind codes.
  localparam logic [2:0] ACT_ACQUIRE       = 3'h0;
  localparam logic [2:0] ACT_PREEMPT       = 3'h1;
  localparam logic [2:0] ACT_PREEMPT_ABORT = 3'h2;
  localparam logic [7:0] KIND_FIRST        = 8'h01;
  localparam logic [7:0] KIND_LAST         = 8'h06;

  // ********************************************************************
  // Key structure and host memory fetch.
  // ********************************************************************
  localparam int unsigned BEATS      = 2;
  localparam logic [63:0] BEAT_BYTES = 64'h8;
  localparam logic [63:0] PAGE_BYTES = 64'h1000;
  localparam logic [31:0] KEY_BYTES  = 32'h10;
  localparam logic [3:0]  SGL_DATA_BLOCK = 4'h0;

  // ********************************************************************
  // Completion status codes, generic status type.
  // ********************************************************************
  localparam logic [7:0] ST_SUCCESS   = 8'h00;
  localparam logic [7:0] ST_BAD_FIELD = 8'h02;
  localparam logic [7:0] ST_XFER_ERR  = 8'h04;
  localparam logic [7:0] ST_SGL_LEN   = 8'h0f;
  localparam logic [7:0] ST_CONFLICT  = 8'h83;

  // ********************************************************************
  // Register map, byte addresses on the word-wide bus.
  // ********************************************************************
  localparam logic [4:0] REG_CTRL     = 5'h00;
  localparam logic [4:0] REG_IRQ_STAT = 5'h04;
  localparam logic [4:0] REG_IRQ_MASK = 5'h08;
  localparam logic [4:0] REG_RES      = 5'h0c;
  localparam logic [4:0] REG_LAST     = 5'h10;
  localparam logic [4:0] REG_COUNT    = 5'h14;
  localparam logic [31:0] CTRL_RESET  = 32'h1;
  localparam logic [2:0]  MASK_RESET  = 3'h0;
  localparam int unsigned EV_DONE     = 0;
  localparam int unsigned EV_ERROR    = 1;
  localparam int unsigned EV_PREEMPT  = 2;

  // Command processing states.
  typedef enum logic [2:0] {
    RAC_IDLE,
    RAC_CHECK,
    RAC_FETCH_REQ,
    RAC_FETCH_RSP,
    RAC_EXEC,
    RAC_COMPLETE
  } rac_state_t;

endpackage

/* src/rac_locator.sv */
// Module that decodes dword 10 and locates each beat of the key structure.
`timescale 1ns/1ps
module rac_locator (
  input  wire logic [31:0]  dword10,
  input  wire logic [127:0] buffer_locator,
  input  wire logic         use_sgl,
  input  wire logic [0:0]   beat,
  output logic [2:0]        acquire_action,
  output logic [7:0]        reservation_kind,
  output logic              skip_key_check,
  output logic              action_ok,
  output logic              kind_ok,
  output logic              sgl_ok,
  output logic [63:0]       beat_addr
);

  // ********************************************************************
  // Field decode.
  // ********************************************************************

  // Action, kind and skip flag come from fixed positions of dword 10.
  always_comb
  begin
    acquire_action   = dword10[rac_pkg::ACTION_LSB +: rac_pkg::ACTION_W];
    reservation_kind = dword10[rac_pkg::KIND_LSB +: rac_pkg::KIND_W];
    skip_key_check   = dword10[rac_pkg::SKIP_BIT];
    action_ok        = (acquire_action == rac_pkg::ACT_ACQUIRE)
                    || (acquire_action == rac_pkg::ACT_PREEMPT)
                    || (acquire_action == rac_pkg::ACT_PREEMPT_ABORT);
    kind_ok          = (reservation_kind >= rac_pkg::KIND_FIRST)
                    && (reservation_kind <= rac_pkg::KIND_LAST);
  end

  // ********************************************************************
  // Beat addressing.
  // ********************************************************************

  // A page list uses entry 1 up to the page end, then entry 2; a
  // descriptor list uses only the first descriptor, a data block.
  logic [63:0] page_list_entry1;
  logic [63:0] page_list_entry2;
  logic [63:0] offset;
  logic [63:0] in_page;
  logic [63:0] room;
  always_comb
  begin
    page_list_entry1 = buffer_locator[63:0];
    page_list_entry2 = buffer_locator[127:64];
    offset           = beat ? rac_pkg::BEAT_BYTES : 64'h0;
    in_page          = page_list_entry1 & (rac_pkg::PAGE_BYTES - 64'h1);
    room             = rac_pkg::PAGE_BYTES - in_page;
    sgl_ok           = (buffer_locator[127:124] == rac_pkg::SGL_DATA_BLOCK)
                    && (buffer_locator[95:64] >= rac_pkg::KEY_BYTES);
    if (use_sgl)
      beat_addr = page_list_entry1 + offset;
    else if (offset < room)
      beat_addr = page_list_entry1 + offset;
    else
      beat_addr = page_list_entry2 + (offset - room);
  end

endmodule

/* src/rac_core.sv */
// Top module that executes reservation acquire commands for one namespace.
`timescale 1ns/1ps

// Functional notes
// - Supports acquire, preempt and preempt-with-abort.
// - Parameters from dword 10, keys fetched.
// - Page list uses entries one and two.
// - Descriptor list uses first descriptor only.
// - 128-bit locator addresses the key buffer.
// - Dword 10 bits 15:8 give kind.
// - Kinds 1h to 6h valid, others reserved.
// - Bits 2:0 select action; 3..7 reserved.
// - Skip flag plus registrant bypasses key check.
// - Skip flag without registration fails command.
// - Preempt actions unregister bytes 15:8 key.
// - One completion entry to paired queue.
module rac_core (
  input  wire logic         clk,
  input  wire logic         rstn,
  // Command from the submission queue.
  input  wire logic         cmd_valid,
  output logic              cmd_ready,
  input  wire logic [15:0]  cmd_id,
  input  wire logic [15:0]  cmd_sq_id,
  input  wire logic [15:0]  cmd_host_id,
  input  wire logic         cmd_use_sgl,
  input  wire logic [31:0]  cmd_dword10,
  input  wire logic [127:0] cmd_buffer_locator,
  input  wire logic         host_is_registrant,
  input  wire logic [63:0]  host_key,
  // Host memory read port, one 8-byte beat per request.
  output logic              mem_req_valid,
  input  wire logic         mem_req_ready,
  output logic [63:0]       mem_req_addr,
  input  wire logic         mem_rsp_valid,
  input  wire logic [63:0]  mem_rsp_data,
  input  wire logic         mem_rsp_error,
  // Registrant table and abort requests.
  output logic              unreg_valid,
  output logic [63:0]       unreg_key,
  output logic              abort_valid,
  output logic [15:0]       abort_host_id,
  // Completion entry.
  output logic              cpl_valid,
  input  wire logic         cpl_ready,
  output logic [15:0]       cpl_cq_sq_id,
  output logic [15:0]       cpl_cmd_id,
  output logic [7:0]        cpl_status,
  // Avalon-MM slave.
  input  wire logic [4:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  output logic [31:0]       avs_readdata,
  output logic              avs_waitrequest,
  output logic              irq
);

  // ********************************************************************
  // Command decode.
  // ********************************************************************

  logic [31:0]  dword10_q, dword10_d;
  logic [127:0] locator_q, locator_d;
  logic         use_sgl_q, use_sgl_d;
  logic [0:0]   beat_q, beat_d;
  logic [2:0]   acquire_action;
  logic [7:0]   reservation_kind;
  logic         skip_key_check;
  logic         action_ok;
  logic         kind_ok;
  logic         sgl_ok;
  logic [63:0]  beat_addr;

  rac_locator u_locator (
    .dword10          (dword10_q),
    .buffer_locator   (locator_q),
    .use_sgl          (use_sgl_q),
    .beat             (beat_q),
    .acquire_action   (acquire_action),
    .reservation_kind (reservation_kind),
    .skip_key_check   (skip_key_check),
    .action_ok        (action_ok),
    .kind_ok          (kind_ok),
    .sgl_ok           (sgl_ok),
    .beat_addr        (beat_addr)
  );

  // ********************************************************************
  // Command state machine and reservation state.
  // ********************************************************************

  rac_pkg::rac_state_t state_q, state_d;
  logic [15:0] cmd_id_q, cmd_id_d;
  logic [15:0] sq_id_q, sq_id_d;
  logic [15:0] host_q, host_d;
  logic        registrant_q, registrant_d;
  logic [63:0] reg_key_q, reg_key_d;
  logic [63:0] current_key_q, current_key_d;
  logic [63:0] preempt_key_q, preempt_key_d;
  logic [7:0]  status_q, status_d;
  logic        held_q, held_d;
  logic [15:0] holder_q, holder_d;
  logic [63:0] holder_key_q, holder_key_d;
  logic [7:0]  kind_q, kind_d;
  logic        unreg_d, abort_d, preempt_ev_d;
  logic        preempt_ev_q;
  logic [31:0] ctrl_q;
  logic        finish;

  // Returns success when ok is set, otherwise the given failure status.
  function automatic logic [7:0] pick_status(input logic ok, input logic [7:0] code);
    pick_status = ok ? rac_pkg::ST_SUCCESS : code;
  endfunction

  assign cmd_ready     = (state_q == rac_pkg::RAC_IDLE) && ctrl_q[0];
  assign mem_req_valid = (state_q == rac_pkg::RAC_FETCH_REQ);
  assign cpl_valid     = (state_q == rac_pkg::RAC_COMPLETE);
  assign finish        = cpl_valid && cpl_ready;

  // Next values for the command flow and the reservation held on the namespace.
  always_comb
  begin
    state_d       = state_q;
    dword10_d     = dword10_q;
    locator_d     = locator_q;
    use_sgl_d     = use_sgl_q;
    beat_d        = beat_q;
    cmd_id_d      = cmd_id_q;
    sq_id_d       = sq_id_q;
    host_d        = host_q;
    registrant_d  = registrant_q;
    reg_key_d     = reg_key_q;
    current_key_d = current_key_q;
    preempt_key_d = preempt_key_q;
    status_d      = status_q;
    held_d        = held_q;
    holder_d      = holder_q;
    holder_key_d  = holder_key_q;
    kind_d        = kind_q;
    unreg_d       = 1'b0;
    abort_d       = 1'b0;
    preempt_ev_d  = 1'b0;
    unique case (state_q)
      rac_pkg::RAC_IDLE:
      begin
        if (cmd_valid && cmd_ready)
        begin
          dword10_d    = cmd_dword10;
          locator_d    = cmd_buffer_locator;
          use_sgl_d    = cmd_use_sgl;
          cmd_id_d     = cmd_id;
          sq_id_d      = cmd_sq_id;
          host_d       = cmd_host_id;
          registrant_d = host_is_registrant;
          reg_key_d    = host_key;
          beat_d       = 1'b0;
          state_d      = rac_pkg::RAC_CHECK;
        end
      end
      rac_pkg::RAC_CHECK:
      begin
        // Field checks run before any memory traffic.
        if (!action_ok || !kind_ok)
        begin
          status_d = rac_pkg::ST_BAD_FIELD;
          state_d  = rac_pkg::RAC_COMPLETE;
        end
        else if (use_sgl_q && !sgl_ok)
        begin
          status_d = rac_pkg::ST_SGL_LEN;
          state_d  = rac_pkg::RAC_COMPLETE;
        end
        else if (skip_key_check && !registrant_q)
        begin
          status_d = rac_pkg::ST_CONFLICT;
          state_d  = rac_pkg::RAC_COMPLETE;
        end
        else
          state_d = rac_pkg::RAC_FETCH_REQ;
      end
      rac_pkg::RAC_FETCH_REQ:
      begin
        if (mem_req_ready)
          state_d = rac_pkg::RAC_FETCH_RSP;
      end
      rac_pkg::RAC_FETCH_RSP:
      begin
        if (mem_rsp_valid)
        begin
          if (beat_q == 1'b0)
            current_key_d = mem_rsp_data;
          else
            preempt_key_d = mem_rsp_data;
          if (mem_rsp_error)
          begin
            status_d = rac_pkg::ST_XFER_ERR;
            state_d  = rac_pkg::RAC_COMPLETE;
          end
          else if (beat_q == 1'(rac_pkg::BEATS - 1))
            state_d = rac_pkg::RAC_EXEC;
          else
          begin
            beat_d  = beat_q + 1'b1;
            state_d = rac_pkg::RAC_FETCH_REQ;
          end
        end
      end
      rac_pkg::RAC_EXEC:
      begin
        state_d = rac_pkg::RAC_COMPLETE;
        if (!registrant_q || (!skip_key_check && current_key_q != reg_key_q))
          status_d = rac_pkg::ST_CONFLICT;
        else if (acquire_action == rac_pkg::ACT_ACQUIRE)
        begin
          // An acquire succeeds if free, or if already held the same way.
          status_d = pick_status(!held_q || (holder_q == host_q && kind_q == reservation_kind),
                                 rac_pkg::ST_CONFLICT);
          if (!held_q)
          begin
            held_d       = 1'b1;
            holder_d     = host_q;
            holder_key_d = reg_key_q;
            kind_d       = reservation_kind;
          end
        end
        else
        begin
          // Preempt drops the named key and takes over a reservation it held.
          status_d     = rac_pkg::ST_SUCCESS;
          unreg_d      = 1'b1;
          abort_d      = (acquire_action == rac_pkg::ACT_PREEMPT_ABORT);
          preempt_ev_d = 1'b1;
          if (!held_q || holder_key_q == preempt_key_q)
          begin
            held_d       = 1'b1;
            holder_d     = host_q;
            holder_key_d = reg_key_q;
            kind_d       = reservation_kind;
          end
        end
      end
      rac_pkg::RAC_COMPLETE:
      begin
        if (finish)
          state_d = rac_pkg::RAC_IDLE;
      end
    endcase
    // Software may drop the reservation while no command is running.
    if (avs_write && !avs_waitrequest && avs_address == rac_pkg::REG_CTRL
        && avs_writedata[1] && state_q == rac_pkg::RAC_IDLE)
      held_d = 1'b0;
  end

  // Registers of the command flow.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q       <= rac_pkg::RAC_IDLE;
      dword10_q     <= 32'h0;
      locator_q     <= 128'h0;
      use_sgl_q     <= 1'b0;
      beat_q        <= 1'b0;
      cmd_id_q      <= 16'h0;
      sq_id_q       <= 16'h0;
      host_q        <= 16'h0;
      registrant_q  <= 1'b0;
      reg_key_q     <= 64'h0;
      current_key_q <= 64'h0;
      preempt_key_q <= 64'h0;
      status_q      <= 8'h0;
      held_q        <= 1'b0;
      holder_q      <= 16'h0;
      holder_key_q  <= 64'h0;
      kind_q        <= 8'h0;
      unreg_valid   <= 1'b0;
      abort_valid   <= 1'b0;
      preempt_ev_q  <= 1'b0;
    end
    else
    begin
      state_q       <= state_d;
      dword10_q     <= dword10_d;
      locator_q     <= locator_d;
      use_sgl_q     <= use_sgl_d;
      beat_q        <= beat_d;
      cmd_id_q      <= cmd_id_d;
      sq_id_q       <= sq_id_d;
      host_q        <= host_d;
      registrant_q  <= registrant_d;
      reg_key_q     <= reg_key_d;
      current_key_q <= current_key_d;
      preempt_key_q <= preempt_key_d;
      status_q      <= status_d;
      held_q        <= held_d;
      holder_q      <= holder_d;
      holder_key_q  <= holder_key_d;
      kind_q        <= kind_d;
      unreg_valid   <= unreg_d;
      abort_valid   <= abort_d;
      preempt_ev_q  <= preempt_ev_d;
    end
  end

  assign mem_req_addr  = beat_addr;
  assign unreg_key     = preempt_key_q;
  assign abort_host_id = host_q;
  assign cpl_cq_sq_id  = sq_id_q;
  assign cpl_cmd_id    = cmd_id_q;
  assign cpl_status    = status_q;

  // ********************************************************************
  // Register slave and interrupt.
  // ********************************************************************

  logic [31:0] ctrl_d;
  logic [2:0]  irq_stat_q, irq_stat_d;
  logic [2:0]  irq_mask_q, irq_mask_d;
  logic [31:0] count_q, count_d;
  logic [31:0] rdata_d;
  logic        rd_wait_q, rd_wait_d;
  logic        rd_take;
  logic        wr_take;
  logic [2:0]  ev_set;

  // Reads stall one cycle so read data comes from a flop; writes need none.
  assign avs_waitrequest = avs_read && !rd_wait_q;
  assign rd_take         = avs_read && rd_wait_q;
  assign wr_take         = avs_write && !avs_read;
  assign irq             = |(irq_stat_q & irq_mask_q);

  // Next values; a status read clears only the bits it returned, so new events stay.
  always_comb
  begin
    ev_set             = 3'h0;
    ev_set[rac_pkg::EV_DONE]    = finish;
    ev_set[rac_pkg::EV_ERROR]   = finish && (status_q != rac_pkg::ST_SUCCESS);
    ev_set[rac_pkg::EV_PREEMPT] = preempt_ev_q;
    rd_wait_d  = avs_read && !rd_wait_q;
    ctrl_d     = ctrl_q;
    irq_mask_d = irq_mask_q;
    irq_stat_d = irq_stat_q;
    count_d    = count_q + {31'h0, finish};
    if (rd_take && avs_address == rac_pkg::REG_IRQ_STAT)
      irq_stat_d = irq_stat_q & ~avs_readdata[2:0];
    irq_stat_d = irq_stat_d | ev_set;
    if (wr_take && avs_address == rac_pkg::REG_CTRL)
      ctrl_d = {31'h0, avs_writedata[0]};
    if (wr_take && avs_address == rac_pkg::REG_IRQ_MASK)
      irq_mask_d = avs_writedata[2:0];
    unique case (avs_address)
      rac_pkg::REG_CTRL:     rdata_d = ctrl_q;
      rac_pkg::REG_IRQ_STAT: rdata_d = {29'h0, irq_stat_q};
      rac_pkg::REG_IRQ_MASK: rdata_d = {29'h0, irq_mask_q};
      rac_pkg::REG_RES:      rdata_d = {holder_q, kind_q, 7'h0, held_q};
      rac_pkg::REG_LAST:     rdata_d = {24'h0, status_q};
      rac_pkg::REG_COUNT:    rdata_d = count_q;
      default:               rdata_d = 32'h0;
    endcase
  end

  // Registers of the slave.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_q       <= rac_pkg::CTRL_RESET;
      irq_stat_q   <= 3'h0;
      irq_mask_q   <= rac_pkg::MASK_RESET;
      count_q      <= 32'h0;
      rd_wait_q    <= 1'b0;
      avs_readdata <= 32'h0;
    end
    else
    begin
      ctrl_q       <= ctrl_d;
      irq_stat_q   <= irq_stat_d;
      irq_mask_q   <= irq_mask_d;
      count_q      <= count_d;
      rd_wait_q    <= rd_wait_d;
      avs_readdata <= rdata_d;
    end
  end

endmodule

/* testbench/rac_core_props.sv */
// Checker with the timing properties of the reservation acquire block.
`timescale 1ns/1ps
module rac_core_props (
  input wire logic         clk,
  input wire logic         rstn,
  input wire logic         cmd_valid,
  input wire logic         cmd_ready,
  input wire logic         cmd_use_sgl,
  input wire logic         host_is_registrant,
  input wire logic [31:0]  cmd_dword10,
  input wire logic [127:0] cmd_buffer_locator,
  input wire logic         mem_req_valid,
  input wire logic         mem_req_ready,
  input wire logic [63:0]  mem_req_addr,
  input wire logic         unreg_valid,
  input wire logic         cpl_valid,
  input wire logic         cpl_ready,
  input wire logic [15:0]  cpl_cmd_id,
  input wire logic [7:0]   cpl_status
);
  logic [127:0] loc_q, loc_d;
  logic         sgl_q, sgl_d, take, ok;
  logic [1:0]   beat_q, beat_d;
  logic [63:0]  addr1;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // Tracks the locator in flight and counts accepted beats.
  always_comb
  begin
    take   = cmd_valid & cmd_ready;
    ok     = cmd_dword10[2:0] <= 3'h2 && cmd_dword10[15:8] != 8'h00 && cmd_dword10[15:8] < 8'h07;
    loc_d  = take ? cmd_buffer_locator : loc_q;
    sgl_d  = take ? cmd_use_sgl : sgl_q;
    beat_d = take ? 2'h0 : beat_q + {1'b0, mem_req_valid & mem_req_ready};
    addr1  = (sgl_q || loc_q[11:0] < 12'hff8) ? loc_q[63:0] + 64'h8 : loc_q[127:64];
  end

  // Registers the tracking state.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      loc_q  <= '0;
      sgl_q  <= 1'b0;
      beat_q <= 2'h0;
    end
    else
    begin
      loc_q  <= loc_d;
      sgl_q  <= sgl_d;
      beat_q <= beat_d;
    end
  end

  property p_cpl_hold;
    cpl_valid && !cpl_ready |=> cpl_valid && $stable(cpl_status) && $stable(cpl_cmd_id);
  endproperty
  a_cpl_hold: assert property (p_cpl_hold)
    else $error("completion changed while waiting");
  property p_cpl_once;
    cpl_valid && cpl_ready |=> !cpl_valid [*2];
  endproperty
  a_cpl_once: assert property (p_cpl_once)
    else $error("second completion for one command");
  property p_reject;
    take && !ok |=> !mem_req_valid && !unreg_valid ##1 cpl_valid && cpl_status == 8'h02;
  endproperty
  a_reject: assert property (p_reject)
    else $error("reserved field not rejected");
  property p_skip;
    take && ok && cmd_dword10[3] && !host_is_registrant |-> ##2 cpl_valid && cpl_status == 8'h83;
  endproperty
  a_skip: assert property (p_skip)
    else $error("skip without registration not failed");
  property p_req_hold;
    mem_req_valid && !mem_req_ready |=> mem_req_valid && $stable(mem_req_addr);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("memory request dropped or moved");
  property p_beat0;
    mem_req_valid && beat_q == 2'h0 |-> mem_req_addr == loc_q[63:0];
  endproperty
  a_beat0: assert property (p_beat0)
    else $error("first beat address wrong");
  property p_beat1;
    mem_req_valid && beat_q == 2'h1 |-> mem_req_addr == addr1;
  endproperty
  a_beat1: assert property (p_beat1)
    else $error("second beat address wrong");
  property p_unreg;
    unreg_valid |-> cpl_valid && cpl_status == 8'h00 ##1 !unreg_valid;
  endproperty
  a_unreg: assert property (p_unreg)
    else $error("unregister pulse out of place");

  c_preempt: cover property (unreg_valid);
  c_entry2: cover property (mem_req_valid && beat_q == 2'h1 && !sgl_q && loc_q[11:0] >= 12'hff8);
  c_stall: cover property (cpl_valid && !cpl_ready);
endmodule

bind rac_core rac_core_props u_rac_core_props (.*);

/* testbench/rac_host_mem.sv */
// Host memory model that serves the two beats of the key structure.
`timescale 1ns/1ps
module rac_host_mem (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        slow,
  input  wire logic        err,
  input  wire logic [63:0] a0,
  input  wire logic [63:0] a1,
  input  wire logic [63:0] k0,
  input  wire logic [63:0] k1,
  input  wire logic        mem_req_valid,
  output logic             mem_req_ready,
  input  wire logic [63:0] mem_req_addr,
  output logic             mem_rsp_valid,
  output logic [63:0]      mem_rsp_data,
  output logic             mem_rsp_error
);
  logic stall_q;
  logic hit;

  assign hit = mem_req_valid & mem_req_ready;

  // Accepts a request after one or two cycles and answers on the next edge.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stall_q       <= 1'b0;
      mem_req_ready <= 1'b0;
      mem_rsp_valid <= 1'b0;
      mem_rsp_error <= 1'b0;
      mem_rsp_data  <= '0;
    end
    else
    begin
      stall_q       <= slow & ~stall_q;
      mem_req_ready <= mem_req_valid & ~mem_req_ready & ~(slow & ~stall_q);
      mem_rsp_valid <= hit;
      mem_rsp_error <= hit & err;
      // Stray addresses get junk; idle data flips.
      mem_rsp_data  <= hit ? (mem_req_addr == a0 ? k0 : mem_req_addr == a1 ? k1 : ~k0)
                           : ~mem_rsp_data;
    end
  end
endmodule

/* testbench/rac_core_test.sv */
// Self-checking bench for the reservation acquire command block.
`timescale 1ns/1ps
module rac_core_test;
  localparam logic [63:0] KEY  = 64'h0123_4567_89ab_cdef;
  localparam logic [63:0] PKEY = 64'hfeed_0000_0000_0042;
  logic         clk, rstn, cmd_valid, cmd_ready, cmd_use_sgl, host_is_registrant, slow, err;
  logic         mem_req_valid, mem_req_ready, mem_rsp_valid, mem_rsp_error, unreg_valid;
  logic         abort_valid, cpl_valid, cpl_ready, avs_read, avs_write, avs_waitrequest, irq;
  logic [15:0]  cmd_id, cmd_sq_id, cmd_host_id, abort_host_id, cpl_cq_sq_id, cpl_cmd_id;
  logic [31:0]  cmd_dword10, avs_writedata, avs_readdata, rd;
  logic [127:0] cmd_buffer_locator;
  logic [63:0]  host_key, mem_req_addr, mem_rsp_data, unreg_key, a1, k0, k1, got_key;
  logic [7:0]   cpl_status;
  logic [4:0]   avs_address;
  logic [7:0]   bad [3] = '{8'h00, 8'h07, 8'hff};
  int           n_fail, samples_checked, cyc, n_unreg, n_abort;

  rac_core u_rac_core (.*);
  rac_host_mem u_rac_host_mem (
    .clk, .rstn, .slow, .err, .a0(cmd_buffer_locator[63:0]), .a1, .k0, .k1, .mem_req_valid,
    .mem_req_ready, .mem_req_addr, .mem_rsp_valid, .mem_rsp_data, .mem_rsp_error
  );

  // Free-running 40 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic results;
    if (n_fail == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus cycle, held until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  task automatic irq_is(input logic v);
    repeat (2) @(posedge clk);
    check(irq, v);
  endtask

  task automatic loc(input logic scatter_gather_descriptor, input logic [127:0] l, input logic [63:0] b1);
    cmd_use_sgl        <= scatter_gather_descriptor;
    cmd_buffer_locator <= l;
    a1                 <= b1;
  endtask

  // Issues a command and takes its completion a cycle late.
  task automatic cmd(input logic [31:0] d10, input logic [15:0] host, input logic rg,
                     input logic [63:0] cur, input logic [7:0] exp);
    cmd_id             <= cmd_id + 16'h1;
    cmd_dword10        <= d10;
    cmd_host_id        <= host;
    host_is_registrant <= rg;
    k0                 <= cur;
    cmd_valid          <= 1'b1;
    @(posedge clk);
    while (cmd_ready !== 1'b1)
      @(posedge clk);
    cmd_valid <= 1'b0;
    while (cpl_valid !== 1'b1)
      @(posedge clk);
    cpl_ready <= 1'b1;
    @(posedge clk);
    check(cpl_status, exp);
    check(cpl_cmd_id, cmd_id);
    check(cpl_cq_sq_id, cmd_sq_id);
    cpl_ready <= 1'b0;
    @(posedge clk);
  endtask

  // Counts unregister and abort pulses and cuts a hang short.
  always @(posedge clk)
  begin
    cyc++;
    if (unreg_valid === 1'b1)
    begin
      n_unreg++;
      got_key = unreg_key;
    end
    if (abort_valid === 1'b1 && abort_host_id === 16'h0009)
      n_abort++;
    if (cyc == 5000)
    begin
      n_fail++;
      results();
    end
  end

  // Main sequence; other command fields stay fixed.
  initial
  begin
    {rstn, cmd_valid, cmd_use_sgl, host_is_registrant, slow, err, cpl_ready} = '0;
    {avs_read, avs_write, cmd_id, cmd_host_id, cmd_dword10, avs_writedata, avs_address} = '0;
    cmd_sq_id = 16'h0003;
    host_key = KEY;
    k0 = KEY;
    k1 = PKEY;
    loc(1'b0, {64'h0, 64'h1100}, 64'h1108);
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdchk(5'h00, 32'h1);
    rdchk(5'h08, 32'h0);
    rdchk(5'h1c, 32'h0);
    bus(1'b1, 5'h08, 32'h1);
    cmd(32'h0000_0100, 16'h0005, 1'b1, KEY, 8'h00);
    irq_is(1'b1);
    rdchk(5'h04, 32'h1);
    irq_is(1'b0);
    rdchk(5'h0c, 32'h0005_0101);
    cmd(32'h0000_0100, 16'h0005, 1'b1, ~KEY, 8'h83);
    for (int a = 3; a < 8; a++)
      cmd({16'h0, 8'h02, 5'h0, a[2:0]}, 16'h0005, 1'b1, KEY, 8'h02);
    foreach (bad[i])
      cmd({16'h0, bad[i], 8'h00}, 16'h0005, 1'b1, KEY, 8'h02);
    rdchk(5'h0c, 32'h0005_0101);
    cmd(32'h0000_0108, 16'h0005, 1'b1, ~KEY, 8'h00);
    cmd(32'h0000_0108, 16'h0006, 1'b0, KEY, 8'h83);
    for (int k = 1; k < 7; k++)
    begin
      slow <= k[0];
      bus(1'b1, 5'h00, 32'h3);
      cmd({16'h0, k[7:0], 8'h00}, 16'h0005, 1'b1, KEY, 8'h00);
      rdchk(5'h0c, {16'h0005, k[7:0], 8'h01});
    end
    for (int a = 1; a < 3; a++)
    begin
      cmd({16'h0, 8'h02, 5'h0, a[2:0]}, 16'h0009, 1'b1, KEY, 8'h00);
      check(got_key, PKEY);
    end
    check(n_unreg, 2);
    check(n_abort, 1);
    rdchk(5'h04, 32'h7);
    loc(1'b1, {4'h0, 28'h0, 32'h10, 64'h2000}, 64'h2008);
    bus(1'b1, 5'h00, 32'h3);
    cmd(32'h0000_0200, 16'h0005, 1'b1, KEY, 8'h00);
    loc(1'b0, {64'h5000, 64'h3ff8}, 64'h5000);
    bus(1'b1, 5'h00, 32'h3);
    cmd(32'h0000_0300, 16'h0005, 1'b1, KEY, 8'h00);
    err <= 1'b1;
    bus(1'b1, 5'h00, 32'h3);
    cmd(32'h0000_0100, 16'h0005, 1'b1, KEY, 8'h04);
    results();
  end
endmodule
